/* File: motor_ctrl_map.svh */
`ifndef MOTOR_CTRL_MAP_SVH
`define MOTOR_CTRL_MAP_SVH

// ----------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------
// Core clock rate in MHz
`define CLK_FREQ_MHZ 50
// Wake delay in microseconds
`define WAKE_DELAY_US 1000
// Sleep entry delay in microseconds
`define SLEEP_ENTRY_DELAY_US 1000
// Overcurrent retry interval in microseconds
`define RETRY_INTERVAL_US 2000
// Width of the mode timers
`define TIMER_W 24

// ----------------------------------------------------------------------
// Follower address
// ----------------------------------------------------------------------
// Fixed upper part of the 7-bit follower address (write byte 8'h60)
`define ADDR_UPPER 7'h30
// Three-level strap codes
`define STRAP_LOW 2'h0
`define STRAP_OPEN 2'h1
`define STRAP_HIGH 2'h2

// ----------------------------------------------------------------------
// Status register served by this block
// ----------------------------------------------------------------------
`define STATUS_REG_ADDR 8'h00
`define STATUS_RESET 8'h00
`define STATUS_FAULT_BIT 7
`define STATUS_OVERCURRENT_BIT 4
`define STATUS_OVERVOLTAGE_BIT 3
`define STATUS_OVERTEMP_BIT 2

`endif

/* File: motor_ctrl_pkg.sv */
package motor_ctrl_pkg;

	// Device operating mode
	typedef enum logic [1:0] {
		mode_sleep,
		mode_idle,
		mode_active,
		mode_fault
	} mode_t;

	// Follower engine state
	typedef enum logic [2:0] {
		fol_idle,
		fol_rx,
		fol_ack,
		fol_tx,
		fol_rack
	} fol_state_t;

	// Which byte of a transfer is being received
	typedef enum logic [1:0] {
		byte_addr,
		byte_reg,
		byte_data
	} byte_kind_t;

endpackage

/* File: i2c_follower.sv */
`timescale 1ns/1ps
`default_nettype none
`include "motor_ctrl_map.svh"

// Follower engine on the link clock; scl/sda are oversampled
module i2c_follower import motor_ctrl_pkg::*; (
	// Link clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Bus pins
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	// Address straps, three-level codes
	input wire logic [1:0] strap_zero_i,
	input wire logic [1:0] strap_one_i,
	// Write event toward the core domain
	output logic wr_tgl_o,
	output logic [7:0] wr_addr_o,
	output logic [7:0] wr_data_o,
	// Read handshake with the core domain
	output logic rd_req_tgl_o,
	input wire logic rd_ack_tgl_i,
	input wire logic [7:0] rd_data_i
);

	// ------------------------------------------------------------------
	// Synchronisers and strap capture
	// ------------------------------------------------------------------
	logic [2:0] in_s1_r; // First stage: scl, sda, ack toggle
	logic [2:0] in_s2_r; // Second stage
	logic scl_q_r; // Delayed scl for edges
	logic sda_q_r; // Delayed sda for edges
	logic [3:0] strap_s1_r; // Strap first stage
	logic [3:0] strap_s2_r; // Strap second stage
	logic [1:0] strap_age_r; // Fills as real strap levels reach stage two
	logic strap_done_r; // Straps taken once
	logic [6:0] my_addr_r; // Own 7-bit address

	// Strap code: high level times three plus low level
	function automatic logic [3:0] strap_code(input logic [1:0] hi, input logic [1:0] lo);
		strap_code = 4'(({2'h0, hi} << 1) + {2'h0, hi} + {2'h0, lo});
	endfunction

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			in_s1_r <= 3'h3;
			in_s2_r <= 3'h3;
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
			strap_s1_r <= 4'h0;
			strap_s2_r <= 4'h0;
			strap_age_r <= 2'h0;
		end else begin
			in_s1_r <= {rd_ack_tgl_i, sda_i, scl_i};
			in_s2_r <= in_s1_r;
			scl_q_r <= in_s2_r[0];
			sda_q_r <= in_s2_r[1];
			strap_s1_r <= {strap_one_i, strap_zero_i};
			strap_s2_r <= strap_s1_r;
			strap_age_r <= {strap_age_r[0], 1'b1};
		end
	end

	// Latch the address once after reset; later strap moves are ignored
	// Waits for the pipe to fill, else the reset value would become the address
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			strap_done_r <= 1'b0;
			my_addr_r <= `ADDR_UPPER;
		end else if (!strap_done_r && strap_age_r[1] && scl_q_r) begin
			strap_done_r <= 1'b1;
			my_addr_r <= `ADDR_UPPER + {3'h0, strap_code(strap_s2_r[3:2], strap_s2_r[1:0])};
		end
	end

	// ------------------------------------------------------------------
	// Bus condition decode
	// ------------------------------------------------------------------
	wire scl_w = in_s2_r[0];
	wire sda_w = in_s2_r[1];
	wire scl_rise = scl_w & ~scl_q_r;
	wire scl_fall = ~scl_w & scl_q_r;
	wire start_w = scl_w & scl_q_r & sda_q_r & ~sda_w;
	wire stop_w = scl_w & scl_q_r & ~sda_q_r & sda_w;

	// ------------------------------------------------------------------
	// Byte engine
	// ------------------------------------------------------------------
	fol_state_t st_r; // Engine state
	byte_kind_t kind_r; // Byte being received
	logic [3:0] cnt_r; // Bit counter
	logic [7:0] shr_r; // Shift register
	logic oe_r; // Pulls sda low while set
	logic rd_go_r; // Address byte asked for a read
	logic [7:0] rdat_r; // Read byte taken from the core
	// General call 7'h00 can never equal the address, which is at least 7'h30
	wire addr_hit = strap_done_r && (shr_r[7:1] == my_addr_r);

	assign sda_o = 1'b0;
	assign sda_oe_o = oe_r;

	// Take read data only once the handshake has closed, so it is stable
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdat_r <= 8'h00;
		end else if (in_s2_r[2] == rd_req_tgl_o) begin
			rdat_r <= rd_data_i;
		end
	end

	// Start and stop override every state
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_r <= fol_idle;
			kind_r <= byte_addr;
			cnt_r <= 4'h0;
			shr_r <= 8'h00;
			oe_r <= 1'b0;
			rd_go_r <= 1'b0;
			wr_tgl_o <= 1'b0;
			wr_addr_o <= 8'h00;
			wr_data_o <= 8'h00;
			rd_req_tgl_o <= 1'b0;
		end else if (start_w) begin
			st_r <= fol_rx;
			kind_r <= byte_addr;
			cnt_r <= 4'h0;
			oe_r <= 1'b0;
			rd_go_r <= 1'b0;
		end else if (stop_w) begin
			st_r <= fol_idle;
			oe_r <= 1'b0;
		end else begin
			case (st_r)
				fol_rx: begin
					if (scl_rise) begin
						shr_r <= {shr_r[6:0], sda_w};
						cnt_r <= cnt_r + 4'h1;
					end else if (scl_fall && cnt_r == 4'h8) begin
						cnt_r <= 4'h0;
						if (kind_r == byte_addr && !addr_hit) begin
							st_r <= fol_idle;
						end else begin
							oe_r <= 1'b1;
							st_r <= fol_ack;
							kind_r <= (kind_r == byte_addr) ? byte_reg : byte_data;
							if (kind_r == byte_addr) begin
								rd_go_r <= shr_r[0];
							end else if (kind_r == byte_reg) begin
								// Register address also starts a read fetch
								wr_addr_o <= shr_r;
								rd_req_tgl_o <= ~rd_req_tgl_o;
							end else begin
								wr_data_o <= shr_r;
								wr_tgl_o <= ~wr_tgl_o;
							end
						end
					end
				end
				fol_ack: begin
					if (scl_fall) begin
						oe_r <= rd_go_r ? ~rdat_r[7] : 1'b0;
						shr_r <= rdat_r;
						st_r <= rd_go_r ? fol_tx : fol_rx;
					end
				end
				fol_tx: begin
					if (scl_rise) begin
						cnt_r <= cnt_r + 4'h1;
					end else if (scl_fall && cnt_r == 4'h8) begin
						oe_r <= 1'b0;
						cnt_r <= 4'h0;
						st_r <= fol_rack;
					end else if (scl_fall) begin
						shr_r <= {shr_r[6:0], 1'b0};
						oe_r <= ~shr_r[6];
					end
				end
				fol_rack: begin
					if (scl_rise) begin
						cnt_r <= {3'h0, ~sda_w};
					end else if (scl_fall && cnt_r == 4'h1) begin
						// Leader acknowledged: send the byte again
						cnt_r <= 4'h0;
						shr_r <= rdat_r;
						oe_r <= ~rdat_r[7];
						st_r <= fol_tx;
					end else if (scl_fall) begin
						st_r <= fol_idle;
					end
				end
				default: begin
					oe_r <= 1'b0;
				end
			endcase
		end
	end

endmodule

`default_nettype wire

/* File: motor_fault_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "motor_ctrl_map.svh"

// What this block does
// - Fault output released at reset, low on faults
// - Active needs supply, sleep high, wake, enable
// - Sleep after low input; wake after delay
// - Fault mode disables bridge, returns on recovery
// - Overcurrent latches or retries by response select
// - Overtemperature latches or recovers by response select
// - Overvoltage only when hi-z, status only, automatic
// - Follower only, general call never acknowledged
// - Straps sampled once after reset
// - Address code is high times three plus low
// - Acknowledge own address and register byte
// - Read: repeated start, acknowledge, drive byte
// - After read nack and stop, release data
// - Latched overcurrent holds until clear command
module motor_fault_ctrl import motor_ctrl_pkg::*; #(
	parameter int unsigned WAKE_CYC = `WAKE_DELAY_US * `CLK_FREQ_MHZ,
	parameter int unsigned TURNOFF_CYC = `SLEEP_ENTRY_DELAY_US * `CLK_FREQ_MHZ,
	parameter int unsigned RETRY_CYC = `RETRY_INTERVAL_US * `CLK_FREQ_MHZ
) (
	// Core clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Link clock
	input wire logic link_clk_i,
	// Bus pins
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	// Address straps, three-level codes
	input wire logic [1:0] addr_strap_zero_i,
	input wire logic [1:0] addr_strap_one_i,
	// Sleep pin and analog comparators
	input wire logic sleep_in_n_i,
	input wire logic supply_low_i,
	input wire logic overcurrent_i,
	input wire logic overtemp_i,
	input wire logic overvoltage_i,
	// Control bits
	input wire logic out_enable_i,
	input wire logic overcurrent_response_sel_i,
	input wire logic thermal_response_sel_i,
	input wire logic clear_faults_cmd_i,
	// Bridge and mode outputs
	output logic bridge_en_o,
	output logic bridge_hiz_o,
	output logic internal_en_o,
	output mode_t mode_o,
	output logic [7:0] status_o,
	// Open-drain fault pin
	output logic fault_out_n_o,
	output logic fault_out_n_oe_o,
	// Register write and read toward the register file
	output logic wr_stb_o,
	output logic [7:0] wr_addr_o,
	output logic [7:0] wr_data_o,
	output logic [7:0] rd_addr_o,
	input wire logic [7:0] rd_data_i
);

	// ------------------------------------------------------------------
	// Timer targets
	// ------------------------------------------------------------------
	localparam logic [`TIMER_W-1:0] WAKE_LAST = `TIMER_W'(WAKE_CYC - 1);
	localparam logic [`TIMER_W-1:0] TURNOFF_LAST = `TIMER_W'(TURNOFF_CYC - 1);
	localparam logic [`TIMER_W-1:0] RETRY_LAST = `TIMER_W'(RETRY_CYC - 1);

	// ------------------------------------------------------------------
	// Link-domain reset and follower
	// ------------------------------------------------------------------
	logic lrst_s1_r; // Reset release, first stage
	logic lrst_s2_r; // Reset release, second stage
	logic lnk_wr_tgl; // Write toggle from the link
	logic lnk_req_tgl; // Read request toggle from the link
	logic [7:0] lnk_addr; // Register address held by the link
	logic [7:0] lnk_data; // Write data held by the link
	logic ack_tgl_r; // Read acknowledge toggle to the link
	logic [7:0] rdat_r; // Read byte offered to the link

	// Assert at once, release in step with the link clock
	always_ff @(posedge link_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			lrst_s1_r <= 1'b0;
			lrst_s2_r <= 1'b0;
		end else begin
			lrst_s1_r <= 1'b1;
			lrst_s2_r <= lrst_s1_r;
		end
	end

	i2c_follower u_follower (
		.clk_i(link_clk_i),
		.rst_b_i(lrst_s2_r),
		.scl_i(scl_i),
		.sda_i(sda_i),
		.sda_o(sda_o),
		.sda_oe_o(sda_oe_o),
		.strap_zero_i(addr_strap_zero_i),
		.strap_one_i(addr_strap_one_i),
		.wr_tgl_o(lnk_wr_tgl),
		.wr_addr_o(lnk_addr),
		.wr_data_o(lnk_data),
		.rd_req_tgl_o(lnk_req_tgl),
		.rd_ack_tgl_i(ack_tgl_r),
		.rd_data_i(rdat_r)
	);

	// ------------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------------
	localparam int N_SYNC = 7;
	logic [N_SYNC-1:0] raw_w; // Inputs from outside this clock
	logic [N_SYNC-1:0] s1_r; // First stage, read only by the second
	logic [N_SYNC-1:0] s2_r; // Second stage, safe to use
	logic wr_q_r; // Delayed write toggle
	logic req_q_r; // Delayed request toggle

	assign raw_w = {lnk_req_tgl, lnk_wr_tgl, overvoltage_i, overtemp_i,
		overcurrent_i, supply_low_i, sleep_in_n_i};

	// Comparator outputs idle low; sleep pin idles high after reset
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s1_r <= 7'h01;
			s2_r <= 7'h01;
			wr_q_r <= 1'b0;
			req_q_r <= 1'b0;
		end else begin
			s1_r <= raw_w;
			s2_r <= s1_r;
			wr_q_r <= s2_r[5];
			req_q_r <= s2_r[6];
		end
	end

	wire sleep_hi = s2_r[0];
	wire uv_w = s2_r[1];
	wire oc_w = s2_r[2];
	wire ot_w = s2_r[3];
	wire ov_w = s2_r[4];
	wire wr_edge = s2_r[5] ^ wr_q_r;
	wire req_edge = s2_r[6] ^ req_q_r;

	// ------------------------------------------------------------------
	// Register traffic from the link
	// ------------------------------------------------------------------
	logic rd_pend_r; // Read address captured, data due next cycle

	// Link holds address and data stable until its next toggle
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wr_stb_o <= 1'b0;
			wr_addr_o <= 8'h00;
			wr_data_o <= 8'h00;
		end else begin
			wr_stb_o <= wr_edge;
			if (wr_edge) begin
				wr_addr_o <= lnk_addr;
				wr_data_o <= lnk_data;
			end
		end
	end

	// Fetch in two steps so the outer register file sees a stable address
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rd_addr_o <= 8'h00;
			rd_pend_r <= 1'b0;
			rdat_r <= 8'h00;
			ack_tgl_r <= 1'b0;
		end else begin
			rd_pend_r <= req_edge;
			if (req_edge) begin
				rd_addr_o <= lnk_addr;
			end
			if (rd_pend_r) begin
				rdat_r <= (rd_addr_o == `STATUS_REG_ADDR) ? status_o : rd_data_i;
				ack_tgl_r <= ~ack_tgl_r;
			end
		end
	end

	// ------------------------------------------------------------------
	// Fault flags
	// ------------------------------------------------------------------
	logic oc_flag_r; // Overcurrent shutdown in force
	logic ts_flag_r; // Overtemperature shutdown in force
	logic ts_seen_r; // Overtemperature seen since last clear
	logic ov_flag_r; // Overvoltage while outputs are hi-z
	logic [`TIMER_W-1:0] retry_cnt_r; // Retry interval timer

	wire oc_set = oc_w & bridge_en_o;
	wire retry_done = overcurrent_response_sel_i & oc_flag_r & (retry_cnt_r == RETRY_LAST);
	wire oc_clr = (~overcurrent_response_sel_i & clear_faults_cmd_i) | retry_done;
	// Overtemperature may only clear once the die has cooled
	wire ts_clr = ~ot_w & (thermal_response_sel_i | clear_faults_cmd_i);
	wire fault_any = uv_w | oc_flag_r | ts_flag_r;

	// A new event in the clearing cycle keeps its flag set
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			oc_flag_r <= 1'b0;
			ts_flag_r <= 1'b0;
			ts_seen_r <= 1'b0;
			ov_flag_r <= 1'b0;
		end else begin
			oc_flag_r <= oc_set | (oc_flag_r & ~oc_clr);
			ts_flag_r <= ot_w | (ts_flag_r & ~ts_clr);
			ts_seen_r <= ot_w | (ts_seen_r & ~clear_faults_cmd_i);
			ov_flag_r <= ov_w & bridge_hiz_o;
		end
	end

	// Retry timer runs only while an auto-retry shutdown is pending
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			retry_cnt_r <= '0;
		end else if (oc_flag_r && overcurrent_response_sel_i && !retry_done) begin
			retry_cnt_r <= retry_cnt_r + `TIMER_W'(1);
		end else begin
			retry_cnt_r <= '0;
		end
	end

	// ------------------------------------------------------------------
	// Operating mode
	// ------------------------------------------------------------------
	mode_t mode_r; // Present mode
	mode_t mode_nxt; // Next mode
	logic [`TIMER_W-1:0] slp_cnt_r; // Sleep pin dwell timer

	// Counts how long the pin has disagreed with the present mode
	wire asleep = (mode_r == mode_sleep);
	wire pin_moving = asleep ? sleep_hi : ~sleep_hi;
	wire wake_done = asleep & sleep_hi & (slp_cnt_r == WAKE_LAST);
	wire turnoff_done = ~asleep & ~sleep_hi & (slp_cnt_r == TURNOFF_LAST);

	always_comb begin
		mode_nxt = mode_r;
		case (mode_r)
			mode_sleep: begin
				if (wake_done) begin
					mode_nxt = mode_idle;
				end
			end
			mode_idle: begin
				if (turnoff_done) begin
					mode_nxt = mode_sleep;
				end else if (fault_any) begin
					mode_nxt = mode_fault;
				end else if (out_enable_i) begin
					mode_nxt = mode_active;
				end
			end
			mode_active: begin
				if (turnoff_done) begin
					mode_nxt = mode_sleep;
				end else if (fault_any) begin
					mode_nxt = mode_fault;
				end else if (!out_enable_i) begin
					mode_nxt = mode_idle;
				end
			end
			mode_fault: begin
				if (turnoff_done) begin
					mode_nxt = mode_sleep;
				end else if (!fault_any) begin
					// Passes through idle, so active again one cycle later
					mode_nxt = mode_idle;
				end
			end
			default: begin
				mode_nxt = mode_sleep;
			end
		endcase
	end

	// Timer restarts whenever the mode changes or the pin settles back
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			mode_r <= mode_sleep;
			slp_cnt_r <= '0;
		end else begin
			mode_r <= mode_nxt;
			if (mode_nxt != mode_r || !pin_moving) begin
				slp_cnt_r <= '0;
			end else if (!wake_done && !turnoff_done) begin
				slp_cnt_r <= slp_cnt_r + `TIMER_W'(1);
			end
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign fault_out_n_o = 1'b0;
	assign mode_o = mode_r;

	// All outputs come from flops so they never glitch
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			bridge_en_o <= 1'b0;
			bridge_hiz_o <= 1'b1;
			internal_en_o <= 1'b0;
			fault_out_n_oe_o <= 1'b0;
			status_o <= `STATUS_RESET;
		end else begin
			bridge_en_o <= (mode_nxt == mode_active);
			bridge_hiz_o <= (mode_nxt != mode_active);
			internal_en_o <= (mode_nxt != mode_sleep) & ~uv_w;
			// Overvoltage is reported only in status, never on the pin
			fault_out_n_oe_o <= fault_any;
			status_o <= 8'h00;
			status_o[`STATUS_FAULT_BIT] <= fault_any;
			status_o[`STATUS_OVERCURRENT_BIT] <= oc_flag_r;
			status_o[`STATUS_OVERVOLTAGE_BIT] <= ov_flag_r;
			status_o[`STATUS_OVERTEMP_BIT] <= ts_seen_r;
		end
	end

endmodule

`default_nettype wire

/* File: motor_fault_ctrl_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Port-level checks of modes, faults and the data line
// ------------------------------------------------------------
module motor_fault_ctrl_checker import motor_ctrl_pkg::*; (
	// Clocks and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic link_clk_i,
	// Watched inputs
	input wire logic scl_i,
	input wire logic supply_low_i,
	input wire logic out_enable_i,
	input wire logic overcurrent_response_sel_i,
	input wire logic clear_faults_cmd_i,
	// Watched outputs
	input wire logic sda_oe_o,
	input wire logic bridge_en_o,
	input wire logic bridge_hiz_o,
	input wire logic internal_en_o,
	input wire mode_t mode_o,
	input wire logic [7:0] status_o,
	input wire logic fault_out_n_oe_o,
	input wire logic wr_stb_o
);
	chk_sleep_dark: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		mode_o == mode_sleep |-> !bridge_en_o && !internal_en_o) else $error("awake in sleep");
	chk_uv_stop: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		supply_low_i [*6] |-> !internal_en_o && !bridge_en_o && fault_out_n_oe_o)
		else $error("undervoltage ignored");
	chk_enable_cause: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		$rose(bridge_en_o) |-> $past(out_enable_i)) else $error("bridge on without enable");
	chk_oc_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		!$past(overcurrent_response_sel_i) && !$past(clear_faults_cmd_i) && status_o[4]
		|=> status_o[4]) else $error("latched overcurrent dropped");
	chk_oc_off: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		status_o[4] |=> !bridge_en_o) else $error("bridge on during overcurrent");
	chk_fault_pin: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		supply_low_i [*4] |-> fault_out_n_oe_o) else $error("fault pin not pulled");
	chk_ov_hiz: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		status_o[3] |-> bridge_hiz_o || $past(bridge_hiz_o)) else $error("overvoltage while driving");
	chk_sda_turn: assert property (@(posedge link_clk_i) disable iff (!rst_b_i)
		$changed(sda_oe_o) |-> !scl_i) else $error("data moved with clock high");
	// Main scenarios reached
	cover property (@(posedge clk_i) disable iff (!rst_b_i) wr_stb_o);
	cover property (@(posedge clk_i) disable iff (!rst_b_i) mode_o == mode_fault);
	cover property (@(posedge link_clk_i) disable iff (!rst_b_i) $rose(sda_oe_o));
endmodule
bind motor_fault_ctrl motor_fault_ctrl_checker motor_fault_ctrl_checker_inst (
	.clk_i(clk_i), .rst_b_i(rst_b_i), .link_clk_i(link_clk_i), .scl_i(scl_i),
	.supply_low_i(supply_low_i), .out_enable_i(out_enable_i),
	.overcurrent_response_sel_i(overcurrent_response_sel_i),
	.clear_faults_cmd_i(clear_faults_cmd_i), .sda_oe_o(sda_oe_o), .bridge_en_o(bridge_en_o),
	.bridge_hiz_o(bridge_hiz_o), .internal_en_o(internal_en_o), .mode_o(mode_o),
	.status_o(status_o), .fault_out_n_oe_o(fault_out_n_oe_o), .wr_stb_o(wr_stb_o));
`default_nettype wire

/* File: i2c_leader_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Bus leader: clock runs only inside frames
// ------------------------------------------------------------
module i2c_leader_model (
	// Resolved data line
	input wire logic sda_i,
	// Clock and data pull-down
	output logic scl_o,
	output logic sda_low_o
);
	// Quarter bit time in ns
	localparam int Q = 250;
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end
	// Data moves while clock is low, sampled mid-high
	task automatic slot(input logic b, output logic s);
		sda_low_o = !b;
		#Q scl_o = 1'b1;
		#Q s = sda_i;
		#Q scl_o = 1'b0;
		#Q;
	endtask
	// Start, also used as repeated start
	task automatic start();
		sda_low_o = 1'b0;
		#Q scl_o = 1'b1;
		#Q sda_low_o = 1'b1;
		#Q scl_o = 1'b0;
		#Q;
	endtask
	task automatic stop();
		sda_low_o = 1'b1;
		#Q scl_o = 1'b1;
		#Q sda_low_o = 1'b0;
		#Q;
	endtask
	// Byte out, most significant bit first; returns acknowledge
	task automatic send(input logic [7:0] v, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) slot(v[i], s);
		slot(1'b1, s);
		ack = !s;
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] r, v, output logic [2:0] k);
		start();
		send({a, 1'b0}, k[2]);
		send(r, k[1]);
		send(v, k[0]);
		stop();
	endtask
	task automatic rd(input logic [6:0] a, input logic [7:0] r, output logic [7:0] v,
		output logic [2:0] k);
		logic s;
		start();
		send({a, 1'b0}, k[2]);
		send(r, k[1]);
		start();
		send({a, 1'b1}, k[0]);
		for (int i = 7; i >= 0; i--) begin
			slot(1'b1, s);
			v[i] = s;
		end
		slot(1'b1, s);
		stop();
	endtask
endmodule
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Bench: modes, faults and follower traffic
// ------------------------------------------------------------
module tb import motor_ctrl_pkg::*;;
	// Short delays keep the run brief
	localparam int WK = 20;
	localparam int TO = 20;
	localparam int RT = 30;
	logic clk = 1'b0, link_clk = 1'b0, rst_b = 1'b0, sleep_n = 1'b1, sup_low = 1'b0;
	logic oc = 1'b0, ot = 1'b0, ov = 1'b0, clr = 1'b0, out_en = 1'b0, oc_sel = 1'b0;
	logic ts_sel = 1'b0, watch = 1'b0, oe_seen = 1'b0;
	logic [1:0] st0 = 2'h2, st1 = 2'h1;
	logic [7:0] stb_cnt = 8'h00;
	logic scl, sda_low, sda_o, sda_oe, br_en, br_hiz, int_en, f_n, f_oe, stb;
	logic [7:0] status, wa, wd, ra, sa, sd, d;
	logic [2:0] k;
	mode_t mode;
	int n_mismatch = 0;
	int tests_run = 0;
	// Open-drain lines resolved from all drivers
	wire logic sda_line = !(sda_low || (sda_oe && !sda_o));
	wire logic fault_pin = f_oe ? f_n : 1'b1;
	initial forever #10 clk = ~clk;
	initial begin
		#3;
		forever #7.5 link_clk = ~link_clk;
	end
	always @(posedge clk) if (stb === 1'b1) begin
		stb_cnt <= stb_cnt + 8'h01;
		sa <= wa;
		sd <= wd;
	end
	always @(posedge link_clk) if (watch && sda_oe === 1'b1) oe_seen <= 1'b1;
	motor_fault_ctrl #(.WAKE_CYC(WK), .TURNOFF_CYC(TO), .RETRY_CYC(RT)) motor_fault_ctrl_inst (
		.clk_i(clk), .rst_b_i(rst_b), .link_clk_i(link_clk), .scl_i(scl), .sda_i(sda_line),
		.sda_o(sda_o), .sda_oe_o(sda_oe), .addr_strap_zero_i(st0), .addr_strap_one_i(st1),
		.sleep_in_n_i(sleep_n), .supply_low_i(sup_low), .overcurrent_i(oc), .overtemp_i(ot),
		.overvoltage_i(ov), .out_enable_i(out_en), .overcurrent_response_sel_i(oc_sel),
		.thermal_response_sel_i(ts_sel), .clear_faults_cmd_i(clr), .bridge_en_o(br_en),
		.bridge_hiz_o(br_hiz), .internal_en_o(int_en), .mode_o(mode), .status_o(status),
		.fault_out_n_o(f_n), .fault_out_n_oe_o(f_oe), .wr_stb_o(stb), .wr_addr_o(wa),
		.wr_data_o(wd), .rd_addr_o(ra), .rd_data_i(8'h5a));
	i2c_leader_model i2c_leader_model_inst (.sda_i(sda_line), .scl_o(scl), .sda_low_o(sda_low));
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic cmp8(input string n, input logic [7:0] e, g);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic cmp1(input string n, input logic e, g);
		cmp8(n, {7'h0, e}, {7'h0, g});
	endtask
	task automatic summarize();
		$display("%0d checks, %0d mismatches", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// Bounded wait for a mode; a miss ends the run
	task automatic mwait(input mode_t m, input int lim);
		for (int i = 0; i < lim && mode !== m; i++) step(1);
		cmp8("mode", {6'h0, m}, {6'h0, mode});
		if (mode !== m) summarize();
	endtask
	task automatic pulse_clr();
		clr = 1'b1;
		step(1);
		clr = 1'b0;
	endtask
	task automatic t_power();
		cmp1("fault pin", 1'b1, fault_pin);
		step(5);
		st0 = 2'h0;
		st1 = 2'h0;
		step(WK - 9);
		cmp1("early bridge", 1'b0, br_en);
		mwait(mode_idle, 20);
		step(3);
		cmp1("bridge no enable", 1'b0, br_en);
		out_en = 1'b1;
		mwait(mode_active, 3);
		$display("done power");
	endtask
	task automatic t_bus();
		logic [6:0] far [3] = '{7'h00, 7'h30, 7'h36};
		i2c_leader_model_inst.wr(7'h35, 8'h0c, 8'ha7, k);
		cmp8("write acks", 8'h07, {5'h0, k});
		cmp8("write reg", 8'h0c, sa);
		cmp8("write data", 8'ha7, sd);
		i2c_leader_model_inst.rd(7'h35, 8'h05, d, k);
		cmp8("read acks", 8'h07, {5'h0, k});
		cmp8("read data", 8'h5a, d);
		cmp8("read reg", 8'h05, ra);
		cmp1("sda after read", 1'b0, sda_oe);
		watch = 1'b1;
		foreach (far[i]) begin
			i2c_leader_model_inst.wr(far[i], 8'h0c, 8'h11, k);
			cmp8("foreign acks", 8'h00, {5'h0, k});
		end
		watch = 1'b0;
		cmp1("foreign sda", 1'b0, oe_seen);
		cmp8("strobes", 8'h01, stb_cnt);
		$display("done bus");
	endtask
	task automatic t_oc(input logic sel);
		oc_sel = sel;
		oc = 1'b1;
		step(4);
		oc = 1'b0;
		step(2);
		cmp1("oc pin", 1'b0, fault_pin);
		cmp1("oc internal", 1'b1, int_en);
		step(sel ? RT - 10 : RT + 5);
		cmp1("oc bridge", 1'b0, br_en);
		if (!sel) pulse_clr();
		mwait(mode_active, 20);
		cmp1("oc pin free", 1'b1, fault_pin);
		$display("done overcurrent");
	endtask
	task automatic t_hot(input logic sel);
		ts_sel = sel;
		ot = 1'b1;
		step(5);
		cmp1("hot pin", 1'b0, fault_pin);
		ot = 1'b0;
		step(5);
		if (!sel) cmp1("hot latched", 1'b0, br_en);
		if (!sel) pulse_clr();
		mwait(mode_active, 10);
		cmp1("hot seen", sel, status[2]);
		i2c_leader_model_inst.rd(7'h35, 8'h00, d, k);
		cmp8("status read", {5'h0, sel, 2'h0}, d);
		pulse_clr();
		$display("done overtemperature");
	endtask
	task automatic t_uv();
		sup_low = 1'b1;
		step(6);
		cmp1("uv internal", 1'b0, int_en);
		cmp1("uv pin", 1'b0, fault_pin);
		sup_low = 1'b0;
		mwait(mode_active, WK + 10);
		$display("done undervoltage");
	endtask
	task automatic t_sleep();
		sleep_n = 1'b0;
		step(TO - 5);
		cmp8("awake", {6'h0, mode_active}, {6'h0, mode});
		mwait(mode_sleep, 12);
		ov = 1'b1;
		step(5);
		cmp1("ov status", 1'b1, status[3]);
		cmp1("ov pin", 1'b1, fault_pin);
		cmp1("sleep hiz", 1'b1, br_hiz);
		ov = 1'b0;
		sleep_n = 1'b1;
		mwait(mode_active, WK + 10);
		$display("done sleep");
	endtask
	initial begin
		step(20);
		rst_b = 1'b1;
		t_power();
		t_bus();
		t_oc(1'b0);
		t_oc(1'b1);
		t_hot(1'b0);
		t_hot(1'b1);
		t_uv();
		t_sleep();
		summarize();
	end
endmodule
`default_nettype wire
